// [embedded_ram_block.v]
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`include "ram_block_map.vh"

module embedded_ram_block (
  input wire clock,
  input wire sys_rst,
  input wire clr_local,
  input wire clr_global,
  input wire [`ADDR_W-1:0] wr_addr,
  input wire [`DATA_W-1:0] wr_data,
  input wire wr_en,
  input wire wr_ce,
  input wire [`ADDR_W-1:0] rd_addr,
  input wire rd_en,
  input wire rd_ce,
  input wire out_ce,
  output reg [`DATA_W-1:0] rd_data,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest
);

  // ----------------------------------------------------------------
  // Address decoding helpers
  // ----------------------------------------------------------------
  function [`ROW_W-1:0] row_of;
    input [`ADDR_W-1:0] a;
    input [1:0] shape;
    begin
      case (shape)
        `SHAPE_256X16: row_of = a[7:0];
        `SHAPE_512X8: row_of = a[8:1];
        `SHAPE_1024X4: row_of = a[9:2];
        `SHAPE_2048X2: row_of = a[10:3];
        default: row_of = a[7:0];
      endcase
    end
  endfunction

  function [3:0] lane_off;
    input [`ADDR_W-1:0] a;
    input [1:0] shape;
    begin
      case (shape)
        `SHAPE_256X16: lane_off = 4'h0;
        `SHAPE_512X8: lane_off = {a[0], 3'h0};
        `SHAPE_1024X4: lane_off = {a[1:0], 2'h0};
        `SHAPE_2048X2: lane_off = {a[2:0], 1'h0};
        default: lane_off = 4'h0;
      endcase
    end
  endfunction

  function [`DATA_W-1:0] width_mask;
    input [1:0] shape;
    begin
      case (shape)
        `SHAPE_256X16: width_mask = 16'hffff;
        `SHAPE_512X8: width_mask = 16'h00ff;
        `SHAPE_1024X4: width_mask = 16'h000f;
        `SHAPE_2048X2: width_mask = 16'h0003;
        default: width_mask = 16'hffff;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  reg [`CFG_W-1:0] cfg_q;
  reg [`ROW_W-1:0] load_row_q;
  reg [15:0] write_count_q;
  wire [1:0] shape;
  wire dual_mode;
  wire rom_mode;
  wire split_mode;
  wire [5:0] reg_sel;

  assign shape = cfg_q[`CFG_SHAPE_HI:`CFG_SHAPE_LO];
  assign dual_mode = cfg_q[`CFG_DUAL];
  assign rom_mode = cfg_q[`CFG_ROM];
  assign split_mode = cfg_q[`CFG_SPLIT];
  assign reg_sel = cfg_q[`CFG_REG_HI:`CFG_REG_LO];

  // ----------------------------------------------------------------
  // Section enables
  // ----------------------------------------------------------------
  // One system clock; each section advances only on an enable, the read stage on rd_ce
  // or, in split mode, on wr_ce, so outside split mode write and read run at unrelated rates
  wire rd_sect;
  wire out_sect;

  assign rd_sect = split_mode ? wr_ce : rd_ce;
  assign out_sect = split_mode ? out_ce : rd_ce;

  // ----------------------------------------------------------------
  // Port register stages
  // ----------------------------------------------------------------
  // Clear is asynchronous; a glitch on either clear line resets
  // the stages, so drive them from clean logic
  wire clr_any;
  reg [`ADDR_W-1:0] wa_q;
  reg [`DATA_W-1:0] wd_q;
  reg we_q;
  reg [`ADDR_W-1:0] ra_q;
  reg re_q;

  assign clr_any = clr_local | clr_global;

  always @(posedge clock or posedge clr_any) begin
    if (clr_any) begin
      wa_q <= 11'h000;
      wd_q <= 16'h0000;
      we_q <= 1'b0;
      ra_q <= 11'h000;
      re_q <= 1'b0;
    end else if (sys_rst) begin
      wa_q <= 11'h000;
      wd_q <= 16'h0000;
      we_q <= 1'b0;
      ra_q <= 11'h000;
      re_q <= 1'b0;
    end else begin
      if (wr_ce) begin
        wa_q <= wr_addr;
        wd_q <= wr_data;
        we_q <= wr_en;
      end
      if (rd_sect) begin
        ra_q <= rd_addr;
        re_q <= rd_en;
      end
    end
  end

  // Bypass muxes, one per selectable input stage
  wire [`ADDR_W-1:0] wa_eff;
  wire [`DATA_W-1:0] wd_eff;
  wire we_eff;
  wire [`ADDR_W-1:0] ra_sel;
  wire [`ADDR_W-1:0] ra_eff;
  wire re_eff;

  assign wa_eff = reg_sel[`SEL_WADDR] ? wa_q : wr_addr;
  assign wd_eff = reg_sel[`SEL_WDATA] ? wd_q : wr_data;
  assign we_eff = reg_sel[`SEL_WE] ? we_q : wr_en;
  assign ra_sel = reg_sel[`SEL_RADDR] ? ra_q : rd_addr;
  assign re_eff = reg_sel[`SEL_RE] ? re_q : rd_en;
  // Single-port mode shares the write address for reads
  assign ra_eff = dual_mode ? ra_sel : wa_eff;

  // ----------------------------------------------------------------
  // Write strobe and storage
  // ----------------------------------------------------------------
  wire wr_strobe;
  wire [3:0] wr_off;
  wire [`DATA_W-1:0] wr_bits;
  wire [`DATA_W-1:0] wr_mask;
  wire load_strobe;
  wire [`DATA_W-1:0] rd_bits;
  wire [`DATA_W-1:0] peek_bits;
  wire bus_go;

  // User writes are blocked while the array holds a ROM pattern
  assign wr_strobe = we_eff & wr_ce & ~rom_mode;
  assign wr_off = lane_off(wa_eff, shape);
  assign wr_bits = wd_eff << wr_off;
  assign wr_mask = width_mask(shape) << wr_off;
  assign bus_go = (read | write) & ~waitrequest;
  assign load_strobe = bus_go & write & (address == `OFS_ROM_DATA)
    & rom_mode;

  ram_array #(
    .ROWS(`ROWS),
    .ROW_W(`ROW_W),
    .WIDTH(`DATA_W)
  ) i_ram_array (
    .clock(clock),
    .wr_strobe(wr_strobe),
    .wr_row(row_of(wa_eff, shape)),
    .wr_bits(wr_bits),
    .wr_mask(wr_mask),
    .load_strobe(load_strobe),
    .load_row(load_row_q),
    .load_bits(writedata[15:0]),
    .rd_row(row_of(ra_eff, shape)),
    .rd_bits(rd_bits),
    .peek_row(load_row_q),
    .peek_bits(peek_bits)
  );

  // ----------------------------------------------------------------
  // Read output stage
  // ----------------------------------------------------------------
  // The output always leaves a flop; with the stage bypassed it
  // reloads every clock with read enable high instead of waiting for out_ce, or for rd_ce outside split mode
  wire [`DATA_W-1:0] rd_word;
  wire out_load;

  assign rd_word = (rd_bits >> lane_off(ra_eff, shape))
    & width_mask(shape);
  assign out_load = re_eff & (reg_sel[`SEL_DOUT] ? out_sect : 1'b1);

  always @(posedge clock or posedge clr_any) begin
    if (clr_any) begin
      rd_data <= 16'h0000;
    end else if (sys_rst) begin
      rd_data <= 16'h0000;
    end else if (out_load) begin
      rd_data <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle: waitrequest drops in the
  // cycle after the request appears, and the access completes there
  reg [31:0] read_mux;

  always @* begin
    read_mux = 32'h00000000;
    case (address)
      `OFS_CFG: read_mux = {21'h00000, cfg_q};
      `OFS_STATUS: read_mux = {16'h0000, write_count_q};
      `OFS_ROM_ADDR: read_mux = {24'h000000, load_row_q};
      `OFS_ROM_DATA: read_mux = {16'h0000, peek_bits};
      default: read_mux = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else if ((read | write) & waitrequest) begin
      waitrequest <= 1'b0;
      // Writes leave the last read answer standing
      if (read) begin
        readdata <= read_mux;
      end
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      cfg_q <= `CFG_RESET;
      load_row_q <= 8'h00;
    end else if (bus_go & write) begin
      case (address)
        `OFS_CFG: begin
          if (byteenable[0]) begin
            cfg_q[7:0] <= writedata[7:0];
          end
          if (byteenable[1]) begin
            cfg_q[10:8] <= writedata[10:8];
          end
        end
        `OFS_ROM_ADDR: begin
          if (byteenable[0]) begin
            load_row_q <= writedata[7:0];
          end
        end
        // Auto-increment lets a pattern stream in without re-aiming
        `OFS_ROM_DATA: begin
          if (rom_mode) begin
            load_row_q <= load_row_q + 8'h01;
          end
        end
        default: load_row_q <= load_row_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write activity counter
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      write_count_q <= 16'h0000;
    end else if (wr_strobe) begin
      write_count_q <= write_count_q + 16'h0001;
    end
  end

endmodule // embedded_ram_block

// [ram_array.v]
`timescale 1ns/100ps
`include "ram_block_map.vh"

module ram_array #(
  parameter ROWS = `ROWS,
  parameter ROW_W = `ROW_W,
  parameter WIDTH = `DATA_W
) (
  input wire clock,
  input wire wr_strobe,
  input wire [ROW_W-1:0] wr_row,
  input wire [WIDTH-1:0] wr_bits,
  input wire [WIDTH-1:0] wr_mask,
  input wire load_strobe,
  input wire [ROW_W-1:0] load_row,
  input wire [WIDTH-1:0] load_bits,
  input wire [ROW_W-1:0] rd_row,
  output wire [WIDTH-1:0] rd_bits,
  input wire [ROW_W-1:0] peek_row,
  output wire [WIDTH-1:0] peek_bits
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset: contents survive clears, as a real array does
  reg [WIDTH-1:0] mem [0:ROWS-1];
  integer i;

  always @(posedge clock) begin
    if (load_strobe) begin
      mem[load_row] <= load_bits;
    end else if (wr_strobe) begin
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (wr_mask[i]) begin
          mem[wr_row][i] <= wr_bits[i];
        end
      end
    end
  end

  assign rd_bits = mem[rd_row];
  assign peek_bits = mem[peek_row];

endmodule // ram_array

// [ram_block_asserts.sv]
`timescale 1ns/100ps
`include "ram_block_map.vh"
module ram_block_asserts (
  input wire clock,
  input wire sys_rst,
  input wire clr_local,
  input wire clr_global,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [`DATA_W-1:0] rd_data,
  input wire [31:0] readdata,
  input wire waitrequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_reset_state: assert property (disable iff (1'b0)
    sys_rst |=> waitrequest && readdata == 32'h0 && rd_data == 16'h0)
    else $error("reset state wrong");
  a_clear_out: assert property (
    clr_local || clr_global |-> rd_data == 16'h0)
    else $error("rd_data not cleared");
  a_wait_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait cycle");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  a_unmapped_zero: assert property (
    read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_narrow_regs: assert property (
    read && !waitrequest && address[3:2] != 2'h0
      |-> readdata[31:16] == 16'h0)
    else $error("upper readdata bits set");
  a_readdata_hold: assert property (
    !$stable(readdata) |-> read && !waitrequest)
    else $error("readdata moved outside a read");
endmodule // ram_block_asserts

bind embedded_ram_block ram_block_asserts i_ram_block_asserts (
  .clock(clock), .sys_rst(sys_rst), .clr_local(clr_local),
  .clr_global(clr_global), .address(address), .read(read),
  .write(write), .rd_data(rd_data), .readdata(readdata),
  .waitrequest(waitrequest));

// [ram_block_map.vh]
`ifndef RAM_BLOCK_MAP_VH
`define RAM_BLOCK_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CFG 4'h0
`define OFS_STATUS 4'h4
`define OFS_ROM_ADDR 4'h8
`define OFS_ROM_DATA 4'hc

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_SHAPE_LO 0
`define CFG_SHAPE_HI 1
`define CFG_DUAL 2
`define CFG_ROM 3
`define CFG_REG_LO 4
`define CFG_REG_HI 9
`define CFG_SPLIT 10
`define CFG_W 11
`define CFG_RESET 11'h7f4

// Register stage select bits, relative to CFG_REG_LO
`define SEL_WDATA 0
`define SEL_DOUT 1
`define SEL_WADDR 2
`define SEL_WE 3
`define SEL_RADDR 4
`define SEL_RE 5

// ----------------------------------------------------------------
// Shapes
// ----------------------------------------------------------------
`define SHAPE_256X16 2'h0
`define SHAPE_512X8 2'h1
`define SHAPE_1024X4 2'h2
`define SHAPE_2048X2 2'h3

// ----------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------
`define TOTAL_BITS 4096
`define ROWS 256
`define ROW_W 8
`define DATA_W 16
`define ADDR_W 11

`endif

// [ram_user_model.sv]
`timescale 1ns/100ps
`include "ram_block_map.vh"
module ram_user_model (
  input wire clock,
  input wire [`DATA_W-1:0] rd_data,
  output logic [`ADDR_W-1:0] wr_addr,
  output logic [`DATA_W-1:0] wr_data,
  output logic wr_en,
  output logic wr_ce,
  output logic [`ADDR_W-1:0] rd_addr,
  output logic rd_en,
  output logic rd_ce,
  output logic out_ce
);
  initial begin
    {wr_addr, wr_data, wr_en, wr_ce} = '0;
    {rd_addr, rd_en, rd_ce, out_ce} = '0;
  end
  // Two edges so the input stages and the array both see it
  task automatic put(input [`ADDR_W-1:0] a, input [`DATA_W-1:0] d,
                     input ce);
    @(posedge clock);
    wr_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    wr_ce <= ce;
    repeat (2) @(posedge clock);
    // Released address and data go inverted, never keep the last value; the enables drop low
    wr_addr <= ~a;
    wr_data <= ~d;
    wr_en <= 1'b0;
    wr_ce <= 1'b0;
  endtask
  // Write enable low here, so raising wr_ce flushes a staged write
  task automatic get(input [`ADDR_W-1:0] a, output [`DATA_W-1:0] q);
    @(posedge clock);
    rd_addr <= a;
    wr_addr <= a;
    rd_en <= 1'b1;
    {wr_ce, rd_ce, out_ce} <= 3'h7;
    repeat (3) @(posedge clock);
    @(negedge clock);
    q = rd_data;
    @(posedge clock);
    rd_addr <= ~a;
    wr_addr <= ~a;
    rd_en <= 1'b0;
    {wr_ce, rd_ce, out_ce} <= 3'h0;
  endtask
endmodule // ram_user_model

// [tb_embedded_ram_block.sv]
`timescale 1ns/100ps
`include "ram_block_map.vh"
module tb_embedded_ram_block;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clr_local = 1'b0;
  logic clr_global = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  wire [31:0] readdata;
  wire waitrequest;
  wire [`DATA_W-1:0] rd_data, wr_data;
  wire [`ADDR_W-1:0] wr_addr, rd_addr;
  wire wr_en, wr_ce, rd_en, rd_ce, out_ce;
  logic [15:0] m [256];
  logic [10:0] cfgs [4] = '{11'h004, 11'h3f4, 11'h7f4, 11'h000};
  logic [10:0] al [8];
  logic [31:0] q, sq;
  logic [15:0] r, d;
  logic [10:0] a;
  int n_errors = 0;
  int num_checks = 0;
  always #2.5 clock = ~clock;
  embedded_ram_block i_embedded_ram_block (.clock(clock),
    .sys_rst(sys_rst), .clr_local(clr_local), .clr_global(clr_global),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en), .wr_ce(wr_ce),
    .rd_addr(rd_addr), .rd_en(rd_en), .rd_ce(rd_ce), .out_ce(out_ce),
    .rd_data(rd_data), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));
  ram_user_model i_ram_user_model (.clock(clock), .rd_data(rd_data),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en), .wr_ce(wr_ce),
    .rd_addr(rd_addr), .rd_en(rd_en), .rd_ce(rd_ce), .out_ce(out_ce));
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_bus(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: bus %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_mem(input [15:0] got, input [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic bus(input w, input [3:0] ad, input [31:0] wd,
                     output [31:0] rq);
    int n;
    @(posedge clock);
    address <= ad;
    writedata <= wd;
    read <= !w;
    write <= w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rq = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // Lane 0 sits in the low bits of a 16-bit row
  function automatic [15:0] exp_rd(input [10:0] ad, input [1:0] s);
    int w, o;
    w = 16 >> s;
    o = (ad & ((1 << s) - 1)) * w;
    exp_rd = 16'((m[ad >> s] >> o) & ((1 << w) - 1));
  endfunction
  task automatic mput(input [10:0] ad, input [1:0] s, input [15:0] wd);
    int w, o;
    w = 16 >> s;
    o = (ad & ((1 << s) - 1)) * w;
    m[ad >> s] = 16'((m[ad >> s] & ~(((1 << w) - 1) << o)) | (wd << o));
  endtask
  initial begin
    void'($urandom(32'hf5d40431));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b1, 4'he, 32'hffff_ffff, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(i * 4) | 4'(i == 3 ? 2 : 0), 32'h0, q);
      chk_bus(q, i == 0 ? 32'h7f4 : 32'h0);
    end
    foreach (cfgs[c]) begin
      for (int s = 0; s < 4; s++) begin
        bus(1'b1, 4'h0, {21'h0, cfgs[c] | 11'(s)}, q);
        for (int i = 0; i < 8; i++) begin
          al[i] = 11'($urandom % (256 << s));
          d = 16'($urandom) & 16'((1 << (16 >> s)) - 1);
          i_ram_user_model.put(al[i], d, 1'b1);
          mput(al[i], 2'(s), d);
        end
        i_ram_user_model.put(al[0], ~m[al[0] >> s], 1'b0);
        foreach (al[i]) begin
          i_ram_user_model.get(al[i], r);
          chk_mem(r, exp_rd(al[i], 2'(s)));
        end
      end
    end
    bus(1'b1, 4'h0, 32'h00c, q);
    a = 11'($urandom % 250);
    bus(1'b1, 4'h8, {21'h0, a}, q);
    for (int i = 0; i < 2; i++) begin
      d = 16'($urandom);
      bus(1'b1, 4'hc, {16'h0, d}, q);
      m[a + i] = d;
    end
    bus(1'b0, 4'h8, 32'h0, q);
    chk_bus(q, 32'(a) + 32'h2);
    bus(1'b1, 4'h8, {21'h0, a}, q);
    bus(1'b0, 4'hc, 32'h0, q);
    chk_bus(q, {16'h0, m[a]});
    bus(1'b0, 4'h4, 32'h0, sq);
    chk_bus(32'(sq != 32'h0), 32'h1);
    i_ram_user_model.put(a, ~m[a], 1'b1);
    bus(1'b0, 4'h4, 32'h0, q);
    chk_bus(q, sq);
    for (int i = 0; i < 2; i++) begin
      i_ram_user_model.get(a + 11'(i), r);
      chk_mem(r, m[a + i]);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      {clr_global, clr_local} <= 2'(i + 1);
      #1 chk_mem(rd_data, 16'h0);
      @(posedge clock);
      {clr_global, clr_local} <= 2'h0;
      i_ram_user_model.get(a, r);
      chk_mem(r, m[a]);
    end
    give_verdict();
  end
endmodule // tb_embedded_ram_block
